//--- alm_ctrl.sv
// Operation
// [R1] While an alarm pin is asserted and its boost bit is 0 all fans go to full PWM; a 1 leaves fans alone.
// [R2] With its enable bit 0 set, the first pin's timer measures over a window chosen by a 3-bit code, 0.25 s doubling to 8 s at 101.
// [R3] The second pin's timer has its own enable bit 0 and its own 3-bit window field, codes 110 and 111 meaning 8 s.
// [R4] The first pin is driven low whenever any source enabled by bits 1 to 4 exceeds its first-pin limit.
// [R5] The second pin is driven low whenever any source enabled by bits 1 to 4 exceeds its second-pin limit.
// [R6] Bits 7 to 5 of both source registers read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "alm_regs.svh"

module alm_ctrl #(
	parameter int unsigned BASE_WIN_CYCLES =
		`ALM_BASE_WIN_MS * (`ALM_NS_PER_MS / `ALM_CLK_PERIOD_NS)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [3:0] over_one_limit,
	input wire logic [3:0] over_two_limit,
	output logic alarm_pin_one_n,
	output logic alarm_pin_one_oe,
	output logic alarm_pin_two_n,
	output logic alarm_pin_two_oe,
	output logic fan_full_speed,
	output logic irq
);

	// ----------------------------------------
	// Byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_BOOST = 8'(`ALM_IDX_BOOST * 4);
	localparam logic [7:0] ADDR_SRC_ONE = 8'(`ALM_IDX_SRC_ONE * 4);
	localparam logic [7:0] ADDR_SRC_TWO = 8'(`ALM_IDX_SRC_TWO * 4);
	localparam logic [7:0] ADDR_INT_STATUS = 8'(`ALM_IDX_INT_STATUS * 4);
	localparam logic [7:0] ADDR_INT_MASK = 8'(`ALM_IDX_INT_MASK * 4);
	localparam logic [7:0] ADDR_MEAS_ONE = 8'(`ALM_IDX_MEAS_ONE * 4);
	localparam logic [7:0] ADDR_MEAS_TWO = 8'(`ALM_IDX_MEAS_TWO * 4);
	localparam logic [7:0] ADDR_LIVE = 8'(`ALM_IDX_LIVE * 4);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] boost_cfg;
	logic [7:0] src_cfg [2];
	logic [3:0] int_status;
	logic [3:0] int_mask;
	logic [3:0] over_limit [2];
	logic [1:0] pin_on;
	logic [1:0] next_pin_on;
	logic [1:0] boost_dis;
	logic [1:0] tmr_done;
	logic [31:0] tmr_meas [2];
	logic [3:0] int_set;
	logic [3:0] next_int_status;
	logic acc_first;
	logic acc_done;
	logic wr_en;
	logic wr_lane0;
	logic addr_ok;
	logic [31:0] rd_mux;
	logic wr_boost;
	logic [1:0] wr_src;
	logic wr_int_status;
	logic wr_int_mask;
	genvar g;

	alm_tmr_if tif[2] ();

	assign over_limit[0] = over_one_limit;
	assign over_limit[1] = over_two_limit;
	assign boost_dis[0] = boost_cfg[`ALM_BOOST_ONE_BIT];
	assign boost_dis[1] = boost_cfg[`ALM_BOOST_TWO_BIT];

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// One wait state: data is looked up on the first access cycle and
	// a write commits only on the edge where pready is seen high
	assign acc_first = psel && penable && !pready;
	assign acc_done = psel && penable && pready;
	assign wr_lane0 = pstrb[0];
	assign wr_en = acc_done && pwrite && wr_lane0;

	always_comb begin
		case (paddr)
			ADDR_BOOST,
			ADDR_SRC_ONE,
			ADDR_SRC_TWO,
			ADDR_INT_STATUS,
			ADDR_INT_MASK,
			ADDR_MEAS_ONE,
			ADDR_MEAS_TWO,
			ADDR_LIVE: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_first;
			pslverr <= acc_first && !addr_ok;
		end
	end

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Each register tests one strobe, so an address slip shows in one place
	always_comb begin
		wr_boost = 1'b0;
		wr_src = 2'h0;
		wr_int_status = 1'b0;
		wr_int_mask = 1'b0;
		if (wr_en) begin
			case (paddr)
				ADDR_BOOST: begin
					wr_boost = 1'b1;
				end
				ADDR_SRC_ONE: begin
					wr_src[0] = 1'b1;
				end
				ADDR_SRC_TWO: begin
					wr_src[1] = 1'b1;
				end
				ADDR_INT_STATUS: begin
					wr_int_status = 1'b1;
				end
				ADDR_INT_MASK: begin
					wr_int_mask = 1'b1;
				end
				default: begin
					wr_boost = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		case (paddr)
			ADDR_BOOST: begin
				rd_mux = {24'h0, boost_cfg};
			end
			ADDR_SRC_ONE: begin
				rd_mux = {24'h0, src_cfg[0] & `ALM_SRC_WMASK}; // R6
			end
			ADDR_SRC_TWO: begin
				rd_mux = {24'h0, src_cfg[1] & `ALM_SRC_WMASK}; // R6
			end
			ADDR_INT_STATUS: begin
				rd_mux = {28'h0, int_status};
			end
			ADDR_INT_MASK: begin
				rd_mux = {28'h0, int_mask};
			end
			ADDR_MEAS_ONE: begin
				rd_mux = tmr_meas[0];
			end
			ADDR_MEAS_TWO: begin
				rd_mux = tmr_meas[1];
			end
			ADDR_LIVE: begin
				rd_mux = {29'h0, fan_full_speed, pin_on};
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (acc_first && !pwrite) begin
			prdata <= rd_mux;
		end else if (acc_done) begin
			prdata <= 32'h0;
		end
	end

	// ----------------------------------------
	// Boost and window register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_cfg <= `ALM_BOOST_RST;
		end else if (wr_boost) begin
			boost_cfg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Source registers
	// ----------------------------------------
	// Upper bits are never stored, so they cannot steer anything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_cfg[0] <= `ALM_SRC_RST;
			src_cfg[1] <= `ALM_SRC_RST;
		end else begin
			if (wr_src[0]) begin
				src_cfg[0] <= pwdata[7:0] & `ALM_SRC_WMASK; // R6
			end
			if (wr_src[1]) begin
				src_cfg[1] <= pwdata[7:0] & `ALM_SRC_WMASK; // R6
			end
		end
	end

	// ----------------------------------------
	// Alarm pins
	// ----------------------------------------
	// Limit flags come from the conversion logic on this same clock,
	// so they are used without synchronisers
	generate
		for (g = 0; g < 2; g++) begin : gen_pin
			always_comb begin
				next_pin_on[g] = |(over_limit[g] & src_cfg[g][`ALM_SRC_LSB +: 4]); // R4 R5
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_on <= 2'h0;
			alarm_pin_one_n <= 1'b1;
			alarm_pin_one_oe <= 1'b0;
			alarm_pin_two_n <= 1'b1;
			alarm_pin_two_oe <= 1'b0;
		end else begin
			// Driver enable and low level move together, so the line never floats low
			pin_on <= next_pin_on;
			alarm_pin_one_n <= !next_pin_on[0]; // R4
			alarm_pin_one_oe <= next_pin_on[0]; // R4
			alarm_pin_two_n <= !next_pin_on[1]; // R5
			alarm_pin_two_oe <= next_pin_on[1]; // R5
		end
	end

	// ----------------------------------------
	// Fan boost
	// ----------------------------------------
	// Follows the next pin state so the fans change on the same edge
	// as the pin itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_full_speed <= 1'b0;
		end else begin
			fan_full_speed <= |(next_pin_on & ~boost_dis); // R1
		end
	end

	// ----------------------------------------
	// Assertion timers
	// ----------------------------------------
	assign tif[0].en = src_cfg[0][`ALM_TMR_EN_BIT]; // R2
	assign tif[0].win_sel = boost_cfg[`ALM_WIN_ONE_LSB +: 3]; // R2
	assign tif[0].asserted = pin_on[0];
	assign tif[1].en = src_cfg[1][`ALM_TMR_EN_BIT]; // R3
	assign tif[1].win_sel = boost_cfg[`ALM_WIN_TWO_LSB +: 3]; // R3
	assign tif[1].asserted = pin_on[1];

	generate
		for (g = 0; g < 2; g++) begin : gen_tmr
			alm_timer #(
				.BASE_WIN_CYCLES(BASE_WIN_CYCLES)
			) u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.bus(tif[g])
			);
			assign tmr_done[g] = tif[g].done;
			assign tmr_meas[g] = tif[g].meas;
		end
	endgenerate

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// A new event in the clearing cycle survives: set wins over clear
	// Pin bits count only rises, so a held alarm raises one pin event
	assign int_set = {tmr_done, next_pin_on & ~pin_on};

	generate
		for (g = 0; g < 4; g++) begin : gen_int
			always_comb begin
				if (int_set[g]) begin
					next_int_status[g] = 1'b1;
				end else if (wr_int_status && pwdata[g]) begin
					next_int_status[g] = 1'b0;
				end else begin
					next_int_status[g] = int_status[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= `ALM_INT_RST;
		end else begin
			int_status <= next_int_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= `ALM_INT_RST;
		end else if (wr_int_mask) begin
			int_mask <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_int_status & int_mask);
		end
	end

endmodule

`default_nettype wire

//--- alm_regs.svh
`ifndef ALM_REGS_SVH
`define ALM_REGS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define ALM_IDX_BOOST 8'h0d
`define ALM_IDX_SRC_ONE 8'h0e
`define ALM_IDX_SRC_TWO 8'h0f
`define ALM_IDX_INT_STATUS 8'h10
`define ALM_IDX_INT_MASK 8'h11
`define ALM_IDX_MEAS_ONE 8'h12
`define ALM_IDX_MEAS_TWO 8'h13
`define ALM_IDX_LIVE 8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ALM_BOOST_RST 8'h00
`define ALM_SRC_RST 8'h00
`define ALM_INT_RST 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ALM_BOOST_ONE_BIT 0
`define ALM_BOOST_TWO_BIT 1
`define ALM_WIN_ONE_LSB 2
`define ALM_WIN_TWO_LSB 5
`define ALM_TMR_EN_BIT 0
`define ALM_SRC_LSB 1
`define ALM_SRC_WMASK 8'h1f
`define ALM_INT_PIN_LSB 0
`define ALM_INT_TMR_LSB 2
`define ALM_LIVE_FAN_BIT 2

// ----------------------------------------
// Window encoding and timing
// ----------------------------------------
`define ALM_WIN_MAX 3'h5
`define ALM_BASE_WIN_MS 250
`define ALM_CLK_PERIOD_NS 100
`define ALM_NS_PER_MS 1000000

`endif

//--- alm_pkg.sv
package alm_pkg;

	typedef enum logic [1:0] {
		ALM_T_IDLE = 2'h0,
		ALM_T_RUN = 2'h1,
		ALM_T_DONE = 2'h3
	} alm_tmr_state_t;

	typedef logic [2:0] alm_win_t;
	typedef logic [31:0] alm_meas_t;

endpackage

//--- alm_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface alm_tmr_if;
	logic en;
	alm_pkg::alm_win_t win_sel;
	logic asserted;
	logic done;
	alm_pkg::alm_meas_t meas;

	modport ctl (output en, output win_sel, output asserted, input done, input meas);
	modport tmr (input en, input win_sel, input asserted, output done, output meas);
endinterface

`default_nettype wire

//--- alm_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "alm_regs.svh"

module alm_timer #(
	parameter int unsigned BASE_WIN_CYCLES = 2500000
) (
	input wire logic pclk,
	input wire logic presetn,
	alm_tmr_if.tmr bus
);

	alm_pkg::alm_tmr_state_t state;
	alm_pkg::alm_meas_t win_len;
	alm_pkg::alm_meas_t win_cnt;
	alm_pkg::alm_meas_t hi_cnt;
	alm_pkg::alm_win_t sel_clamped;

	// Codes above the largest step all give the longest window
	always_comb begin
		sel_clamped = (bus.win_sel > `ALM_WIN_MAX) ? `ALM_WIN_MAX : bus.win_sel;
	end

	// ----------------------------------------
	// Window sequencer
	// ----------------------------------------
	// Window length is latched at each start so a mid-window change
	// cannot cut a measurement short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= alm_pkg::ALM_T_IDLE;
			win_len <= 32'h0;
			win_cnt <= 32'h0;
			hi_cnt <= 32'h0;
		end else if (!bus.en) begin
			state <= alm_pkg::ALM_T_IDLE;
			win_cnt <= 32'h0;
			hi_cnt <= 32'h0;
		end else begin
			case (state)
				alm_pkg::ALM_T_IDLE: begin
					win_len <= 32'(BASE_WIN_CYCLES) << sel_clamped;
					win_cnt <= 32'h1;
					hi_cnt <= bus.asserted ? 32'h1 : 32'h0;
					state <= alm_pkg::ALM_T_RUN;
				end
				alm_pkg::ALM_T_RUN: begin
					win_cnt <= win_cnt + 32'h1;
					if (bus.asserted) begin
						hi_cnt <= hi_cnt + 32'h1;
					end
					if (win_cnt >= win_len - 32'h1) begin
						state <= alm_pkg::ALM_T_DONE;
					end
				end
				alm_pkg::ALM_T_DONE: begin
					state <= alm_pkg::ALM_T_IDLE;
				end
				default: begin
					state <= alm_pkg::ALM_T_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Result
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.meas <= 32'h0;
			bus.done <= 1'b0;
		end else begin
			bus.done <= 1'b0;
			if (bus.en && state == alm_pkg::ALM_T_DONE) begin
				bus.meas <= hi_cnt;
				bus.done <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

//--- alm_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module alm_ctrl_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [3:0] over_one_limit,
	input wire logic [3:0] over_two_limit,
	input wire logic alarm_pin_one_n,
	input wire logic alarm_pin_one_oe,
	input wire logic alarm_pin_two_n,
	input wire logic alarm_pin_two_oe,
	input wire logic fan_full_speed
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_src_read;
		psel && penable && !pwrite && paddr[7:3] == 5'h07 && !pready ##1 pready;
	endsequence

	a_ready_one_wait: assert property (s_access |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response without ready or with data");
	a_src_reserved: assert property (s_src_read |-> prdata[31:5] == 27'h0)
		else $error("reserved source bits read nonzero");
	a_one_oe_pair: assert property (alarm_pin_one_oe == !alarm_pin_one_n)
		else $error("pin one enable disagrees with level");
	a_two_oe_pair: assert property (alarm_pin_two_oe == !alarm_pin_two_n)
		else $error("pin two enable disagrees with level");
	a_one_cause: assert property (!alarm_pin_one_n |-> $past(|over_one_limit))
		else $error("pin one low without a limit exceeded");
	a_two_cause: assert property (!alarm_pin_two_n |-> $past(|over_two_limit))
		else $error("pin two low without a limit exceeded");
	a_fan_cause: assert property (fan_full_speed |-> !alarm_pin_one_n || !alarm_pin_two_n)
		else $error("fans boosted with no pin asserted");
endmodule

bind alm_ctrl alm_ctrl_props u_alm_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .over_one_limit(over_one_limit), .over_two_limit(over_two_limit),
	.alarm_pin_one_n(alarm_pin_one_n), .alarm_pin_one_oe(alarm_pin_one_oe),
	.alarm_pin_two_n(alarm_pin_two_n), .alarm_pin_two_oe(alarm_pin_two_oe),
	.fan_full_speed(fan_full_speed));

`default_nettype wire

//--- alm_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module alm_far_side (
	input wire logic alarm_pin_one_n,
	input wire logic alarm_pin_one_oe,
	input wire logic alarm_pin_two_n,
	input wire logic alarm_pin_two_oe,
	output logic line_one,
	output logic line_two
);
	// Pull-up holds each shared line high while nobody pulls it down
	assign line_one = alarm_pin_one_oe ? alarm_pin_one_n : 1'b1;
	assign line_two = alarm_pin_two_oe ? alarm_pin_two_n : 1'b1;
endmodule

`default_nettype wire

//--- test_alm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "alm_regs.svh"

module test_alm_ctrl;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0] pstrb, over_one_limit, over_two_limit;
	logic alarm_pin_one_n, alarm_pin_one_oe, alarm_pin_two_n, alarm_pin_two_oe;
	logic fan_full_speed, irq, line_one, line_two;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_rise = 0;
	int last = 0;
	int period = 0;
	int k;

	// Short base window keeps the 8 s code at 512 cycles
	alm_ctrl #(.BASE_WIN_CYCLES(16)) u_alm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .over_one_limit(over_one_limit),
		.over_two_limit(over_two_limit), .alarm_pin_one_n(alarm_pin_one_n),
		.alarm_pin_one_oe(alarm_pin_one_oe), .alarm_pin_two_n(alarm_pin_two_n),
		.alarm_pin_two_oe(alarm_pin_two_oe), .fan_full_speed(fan_full_speed), .irq(irq));
	alm_far_side u_alm_far_side (.alarm_pin_one_n(alarm_pin_one_n),
		.alarm_pin_one_oe(alarm_pin_one_oe), .alarm_pin_two_n(alarm_pin_two_n),
		.alarm_pin_two_oe(alarm_pin_two_oe), .line_one(line_one), .line_two(line_two));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Outputs read before this edge's updates land, so no race
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task lim(input int p, input logic [3:0] v);
		@(posedge pclk);
		if (p != 0)
			over_two_limit <= v;
		else
			over_one_limit <= v;
		repeat (3) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		irq_q <= irq;
		if (irq === 1'b1 && irq_q === 1'b0) begin
			n_rise <= n_rise + 1;
			period <= cyc - last;
			last <= cyc;
		end
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		over_one_limit = 4'h0;
		over_two_limit = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			apb(0, 8'(`ALM_IDX_BOOST + r), 0);
			chk("reset value", rdata, 32'h0);
		end
		for (int p = 0; p < 2; p++) begin
			apb(1, 8'(`ALM_IDX_SRC_ONE + p), 8'hfe);
			apb(0, 8'(`ALM_IDX_SRC_ONE + p), 0);
			chk("source reserved", rdata, 32'h1e);
		end
		apb(0, 8'h30, 0);
		chk("unmapped error", 32'(rerr), 32'h1);
		chk("unmapped data", rdata, 32'h0);
		pstrb <= 4'h0;
		apb(1, `ALM_IDX_BOOST, 8'hff);
		pstrb <= 4'hf;
		apb(0, `ALM_IDX_BOOST, 0);
		chk("strobe off", rdata, 32'h0);
		$display("registers done");
		apb(1, `ALM_IDX_BOOST, 8'h00);
		apb(1, `ALM_IDX_INT_MASK, 8'h00);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				apb(1, 8'(`ALM_IDX_SRC_ONE + p), 8'h02 << i);
				lim(p, ~(4'h1 << i));
				chk("pin idle", 32'(p != 0 ? line_two : line_one), 32'h1);
				lim(p, 4'hf);
				chk("pin low", 32'(p != 0 ? line_two : line_one), 32'h0);
				chk("fan boost", 32'(fan_full_speed), 32'h1);
				apb(0, `ALM_IDX_LIVE, 0);
				chk("live", rdata, 32'h4 | (32'h1 << p));
				lim(p, 4'h0);
			end
		end
		apb(1, `ALM_IDX_BOOST, 8'h01);
		lim(0, 4'hf);
		chk("fan left", 32'(fan_full_speed), 32'h0);
		apb(1, `ALM_IDX_BOOST, 8'h02);
		repeat (2) @(posedge pclk);
		chk("fan boost one", 32'(fan_full_speed), 32'h1);
		lim(0, 4'h0);
		lim(1, 4'hf);
		chk("fan left two", 32'(fan_full_speed), 32'h0);
		lim(1, 4'h0);
		$display("pins done");
		chk("irq masked", 32'(irq), 32'h0);
		apb(0, `ALM_IDX_INT_STATUS, 0);
		chk("status", rdata, 32'h3);
		apb(1, `ALM_IDX_INT_MASK, 8'h01);
		repeat (2) @(posedge pclk);
		chk("irq raised", 32'(irq), 32'h1);
		apb(1, `ALM_IDX_INT_STATUS, 8'h03);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'(irq), 32'h0);
		$display("interrupts done");
		lim(0, 4'h1);
		lim(1, 4'h1);
		for (int t = 0; t < 2; t++) begin
			for (int code = 0; code < 8; code++) begin
				apb(1, 8'(`ALM_IDX_SRC_ONE + t), 8'h00);
				apb(1, `ALM_IDX_BOOST, t != 0 ? {code[2:0], 5'h0} : {3'h0, code[2:0], 2'h0});
				apb(1, `ALM_IDX_INT_MASK, 8'h04 << t);
				apb(1, 8'(`ALM_IDX_SRC_ONE + t), 8'h03);
				repeat (3) begin
					k = n_rise;
					wait (n_rise != k);
					apb(1, `ALM_IDX_INT_STATUS, 8'h0f);
				end
				chk("window", period, (16 << (code > 5 ? 5 : code)) + 1);
				apb(0, 8'(`ALM_IDX_MEAS_ONE + t), 0);
				chk("measure", rdata, 16 << (code > 5 ? 5 : code));
			end
		end
		$display("timers done");
		print_verdict();
	end
endmodule

`default_nettype wire
